// [hw/io_cell_array.sv]
// i/o cell array with periphery control network and apb configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "io_cell_defs.svh"
module io_cell_array
	import io_cell_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// chip-wide pins
	input wire logic chip_reset_n,
	input wire logic chip_oe_n,
	// dedicated low-skew inputs and dedicated clock pins
	input wire logic [5:0] ded_in,
	input wire logic [1:0] ded_clk,
	// first logic cell of each slot's row, and per-cell logic cell controls
	input wire logic [11:0] logic_row_drive,
	input wire logic [7:0] lc_hold_gate,
	input wire logic [7:0] lc_pin_drive,
	// routing channels
	input wire logic [7:0] row_chan_in,
	input wire logic [23:0] col_chan_in,
	output logic [11:0] row_chan_out,
	output logic [3:0] col_chan_out,
	// pins
	input wire logic [7:0] pad_in,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe,
	// low-skew global nets
	output logic low_skew_net_0,
	output logic low_skew_net_1,
	output logic low_skew_net_2,
	output logic low_skew_net_3
);
	// configuration state
	logic [31:0] ctrl;
	logic [11:0] slot_src;
	logic [23:0] slot_pin_lo;
	logic [11:0] slot_pin_hi;
	cell_cfg_t cell_cfg [`N_CELLS];

	// network and cell wiring
	logic [35:0] slot_pin_idx;
	logic [11:0] slot_val;
	periph_bus_t bus;
	logic chip_oe_ok;
	logic [3:0] gdrv;
	logic [3:0] global_val;
	logic [7:0] cell_q;
	logic [15:0] drive_out;

	// apb decode
	logic setup;
	logic access;
	logic [9:0] word;
	logic [9:0] cell_word;
	logic [2:0] cell_idx;
	logic cell_hit;
	logic mapped;
	logic [31:0] next_prdata;

	// slot sources: any dedicated pin, or the row's first logic cell
	assign slot_pin_idx = {slot_pin_hi, slot_pin_lo};
	generate
		for (genvar s = 0; s < `N_SLOTS; s++) begin : g_slot
			assign slot_val[s] = slot_src[s] ?
				ded_in[slot_pin_idx[s*`PIN_IDX_W +: `PIN_IDX_W]] :
				logic_row_drive[s];
		end
	endgenerate

	// slot roles: 0..5 drive only, 6..11 gate plus alternate role
	assign bus.pin_drive = {slot_val[9], slot_val[7], slot_val[5:0]};
	assign bus.hold_gate = slot_val[11:6];
	assign bus.tick_a = slot_val[6];
	assign bus.tick_b = slot_val[11];
	assign bus.wipe_a = slot_val[8];
	assign bus.wipe_b = slot_val[10];

	// chip-wide drive option: low pin tri-states every pin when enabled
	assign chip_oe_ok = !(ctrl[`CTRL_CHIP_OE_BIT] && !chip_oe_n);

	// each global comes from its dedicated pin unless its slot takes over
	assign gdrv = ctrl[`CTRL_GDRV_LSB +: 4];
	assign global_val[0] = gdrv[0] ? slot_val[6] : ded_in[0];
	assign global_val[1] = gdrv[1] ? slot_val[7] : ded_in[1];
	assign global_val[2] = gdrv[2] ? slot_val[9] : ded_in[2];
	assign global_val[3] = gdrv[3] ? slot_val[11] : ded_in[3];

	// registered global net outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_skew_net_0 <= 1'b0;
			low_skew_net_1 <= 1'b0;
			low_skew_net_2 <= 1'b0;
			low_skew_net_3 <= 1'b0;
		end else begin
			low_skew_net_0 <= global_val[0];
			low_skew_net_1 <= global_val[1];
			low_skew_net_2 <= global_val[2];
			low_skew_net_3 <= global_val[3];
		end
	end

	// row-attached cells: eight row channels at this end
	generate
		for (genvar c = 0; c < `N_ROW_CELLS; c++) begin : g_row_cell
			io_cell #(
				.ON_COLUMN(1'b0)
			) u_cell (
				.pclk(pclk),
				.presetn(presetn),
				.cfg(cell_cfg[c]),
				.bus(bus),
				.ded_clk(ded_clk),
				.lc_hold_gate(lc_hold_gate[c]),
				.lc_pin_drive(lc_pin_drive[c]),
				.chip_reset_n(chip_reset_n),
				.chip_oe_ok(chip_oe_ok),
				.chan_in({8'h00, row_chan_in}),
				.pad_in(pad_in[c]),
				.pad_out(pad_out[c]),
				.pad_oe(pad_oe[c]),
				.chan_out(drive_out[2*c +: 2]),
				.cell_q(cell_q[c])
			);
		end
	endgenerate

	// two column-attached cells, each seeing its own channel subset
	generate
		for (genvar k = 0; k < 2; k++) begin : g_col_cell
			io_cell #(
				.ON_COLUMN(1'b1)
			) u_cell (
				.pclk(pclk),
				.presetn(presetn),
				.cfg(cell_cfg[`N_ROW_CELLS + k]),
				.bus(bus),
				.ded_clk(ded_clk),
				.lc_hold_gate(lc_hold_gate[`N_ROW_CELLS + k]),
				.lc_pin_drive(lc_pin_drive[`N_ROW_CELLS + k]),
				.chip_reset_n(chip_reset_n),
				.chip_oe_ok(chip_oe_ok),
				.chan_in(col_chan_in[8*k +: `N_COL_SUB]),
				.pad_in(pad_in[`N_ROW_CELLS + k]),
				.pad_out(pad_out[`N_ROW_CELLS + k]),
				.pad_oe(pad_oe[`N_ROW_CELLS + k]),
				.chan_out(drive_out[2*(`N_ROW_CELLS + k) +: 2]),
				.cell_q(cell_q[`N_ROW_CELLS + k])
			);
		end
	endgenerate

	// channel drive outputs come straight from cell flip-flops
	assign row_chan_out = drive_out[11:0];
	assign col_chan_out = drive_out[15:12];

	// apb phase and address decode
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign word = paddr[11:2];
	assign cell_word = word - 10'(`OFF_CELL_FIRST >> 2);
	assign cell_idx = cell_word[2:0];
	assign cell_hit = (paddr >= `OFF_CELL_FIRST) && (paddr <= `OFF_CELL_LAST);

	// read mux and map check, evaluated in the setup cycle
	always_comb begin
		next_prdata = 32'h0000_0000;
		mapped = 1'b1;
		if (paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
		end else if (cell_hit) begin
			next_prdata = cell_cfg[cell_idx];
		end else begin
			unique case (paddr)
				`OFF_CTRL: next_prdata = ctrl;
				`OFF_SLOT_SRC: next_prdata = {20'h0_0000, slot_src};
				`OFF_SLOT_PIN_LO: next_prdata = {8'h00, slot_pin_lo};
				`OFF_SLOT_PIN_HI: next_prdata = {20'h0_0000, slot_pin_hi};
				`OFF_PIN_STAT: next_prdata = {8'h00, pad_oe, cell_q, pad_in};
				`OFF_NET_STAT: next_prdata = {16'h0000, global_val, slot_val};
				default: mapped = 1'b0;
			endcase
		end
	end

	// zero-wait answer: data and error latched in setup, shown in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : next_prdata;
				pslverr <= !mapped || (pwrite && (paddr == `OFF_PIN_STAT ||
					paddr == `OFF_NET_STAT));
			end else if (!psel) begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	// global control and slot source registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `CTRL_RST;
			slot_src <= `SLOT_SRC_RST;
			slot_pin_lo <= `SLOT_PIN_LO_RST;
			slot_pin_hi <= `SLOT_PIN_HI_RST;
		end else if (access && pwrite && paddr[1:0] == 2'h0) begin
			unique case (paddr)
				`OFF_CTRL: begin
					ctrl <= {24'h00_0000, pwdata[7:4], 3'h0, pwdata[0]};
				end
				`OFF_SLOT_SRC: slot_src <= pwdata[11:0];
				`OFF_SLOT_PIN_LO: slot_pin_lo <= pwdata[23:0];
				`OFF_SLOT_PIN_HI: slot_pin_hi <= pwdata[11:0];
				default: ;
			endcase
		end
	end

	// per-cell configuration words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `N_CELLS; i++) begin
				cell_cfg[i] <= `CELL_CFG_RST;
			end
		end else if (access && pwrite && cell_hit && paddr[1:0] == 2'h0) begin
			cell_cfg[cell_idx] <= {10'h000, pwdata[21:0]};
		end
	end
endmodule : io_cell_array
`default_nettype wire

// [hw/io_cell_defs.svh]
// register offsets, field positions, reset values and sizes of the i/o cell block
//
// Overview of operation
// - each cell: one pin buffer, one register
// - cell acts as input, output or bidirectional
// - cell picks clock, clear, enables from network
// - network: twelve slots, eight drive, six gate
// - logic cells may supply gate and drive directly
// - cell may clock from two dedicated pins
// - slot source: dedicated pin or row logic
// - chip reset clears cell registers, highest priority
// - chip reset pin is active low
// - chip drive option low tri-states every pin
// - six drive-only slots; six shared gate slots
// - four slots may drive low-skew nets
// - input cell drives two row channels
// - output data muxed from row channels, eight
// - column cell: two channels, own mux subset
// - two cells on each column channel end
// - six dedicated low-skew inputs
`ifndef IO_CELL_DEFS_SVH
`define IO_CELL_DEFS_SVH

// sizes
`define N_CELLS 8
`define N_ROW_CELLS 6
`define N_SLOTS 12
`define N_DED_IN 6
`define N_ROW_CH 8
`define N_COL_CH 24
`define N_COL_SUB 16

// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_SLOT_SRC 12'h004
`define OFF_SLOT_PIN_LO 12'h008
`define OFF_SLOT_PIN_HI 12'h00C
`define OFF_CELL_FIRST 12'h010
`define OFF_CELL_LAST 12'h02C
`define OFF_PIN_STAT 12'h030
`define OFF_NET_STAT 12'h034

// field positions
`define CTRL_CHIP_OE_BIT 0
`define CTRL_GDRV_LSB 4
`define PIN_IDX_W 3

// reset values
`define CTRL_RST 32'h0000_0000
`define SLOT_SRC_RST 12'hFFF
`define SLOT_PIN_LO_RST 24'h00_0000
`define SLOT_PIN_HI_RST 12'h000
`define CELL_CFG_RST 32'h0000_0000

`endif

// [hw/io_cell_pkg.sv]
// types shared by the i/o cell block
`default_nettype none
package io_cell_pkg;
	typedef enum logic [1:0] {DIR_IN, DIR_OUT, DIR_BIDIR, DIR_OFF} cell_dir_t;
	typedef enum logic [1:0] {REG_NONE, REG_IN, REG_OUT, REG_SPARE} reg_use_t;

	// per-cell configuration word, lsb first: dir, reg_use, clk, clr, gate, drive, data
	typedef struct packed {
		logic [9:0] spare;
		logic chan2_en;
		logic [4:0] data_sel;
		logic [3:0] oe_sel;
		logic [3:0] ce_sel;
		logic [1:0] clr_sel;
		logic [1:0] clk_sel;
		reg_use_t reg_use;
		cell_dir_t dir;
	} cell_cfg_t;

	// periphery control network as the cells see it
	typedef struct packed {
		logic [7:0] pin_drive;
		logic [5:0] hold_gate;
		logic tick_a;
		logic tick_b;
		logic wipe_a;
		logic wipe_b;
	} periph_bus_t;
endpackage : io_cell_pkg
`default_nettype wire

// [hw/io_cell.sv]
// one i/o cell: pin buffer control, single register, channel mux and drive
`timescale 1ns/1ps
`default_nettype none
module io_cell
	import io_cell_pkg::*;
#(
	parameter bit ON_COLUMN = 1'b0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// configuration and control network
	input wire cell_cfg_t cfg,
	input wire periph_bus_t bus,
	input wire logic [1:0] ded_clk,
	input wire logic lc_hold_gate,
	input wire logic lc_pin_drive,
	input wire logic chip_reset_n,
	input wire logic chip_oe_ok,
	// data paths
	input wire logic [15:0] chan_in,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe,
	output logic [1:0] chan_out,
	output logic cell_q
);
	logic sel_clk;
	logic sel_clr;
	logic sel_ce;
	logic sel_oe;
	logic clk_prev;
	logic tick;
	logic mux_data;
	logic in_data;
	logic drives_in;

	// control selection from the shared network or neighbouring logic
	always_comb begin
		unique case (cfg.clk_sel)
			2'h0: sel_clk = bus.tick_a;
			2'h1: sel_clk = bus.tick_b;
			2'h2: sel_clk = ded_clk[0];
			2'h3: sel_clk = ded_clk[1];
		endcase
		unique case (cfg.clr_sel)
			2'h1: sel_clr = bus.wipe_a;
			2'h2: sel_clr = bus.wipe_b;
			default: sel_clr = 1'b0;
		endcase
		if (cfg.ce_sel < 4'h6) begin
			sel_ce = bus.hold_gate[cfg.ce_sel[2:0]];
		end else if (cfg.ce_sel == 4'h6) begin
			sel_ce = lc_hold_gate;
		end else begin
			sel_ce = 1'b1;
		end
		if (cfg.oe_sel < 4'h8) begin
			sel_oe = bus.pin_drive[cfg.oe_sel[2:0]];
		end else if (cfg.oe_sel == 4'h8) begin
			sel_oe = lc_pin_drive;
		end else begin
			sel_oe = 1'b1;
		end
	end

	// outgoing data from the channel multiplexer, incoming via register or direct
	assign mux_data = chan_in[cfg.data_sel[3:0]];
	assign in_data = (cfg.reg_use == REG_IN) ? cell_q : pad_in;
	assign drives_in = (cfg.dir == DIR_IN) || (cfg.dir == DIR_BIDIR);
	assign tick = sel_clk & ~clk_prev;

	// edge detector on the selected clock source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= sel_clk;
		end
	end

	// the cell register: chip reset first, then clear, then gated capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_q <= 1'b0;
		end else if (!chip_reset_n) begin
			cell_q <= 1'b0;
		end else if (sel_clr) begin
			cell_q <= 1'b0;
		end else if (tick && sel_ce) begin // hold otherwise
			cell_q <= (cfg.reg_use == REG_IN) ? pad_in : mux_data;
		end
	end

	// pin and channel drivers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
			chan_out <= 2'h0;
		end else begin
			pad_out <= (cfg.reg_use == REG_OUT) ? cell_q : mux_data;
			pad_oe <= chip_oe_ok && sel_oe &&
				((cfg.dir == DIR_OUT) || (cfg.dir == DIR_BIDIR));
			chan_out[0] <= drives_in & in_data;
			chan_out[1] <= drives_in & in_data & (~ON_COLUMN | cfg.chan2_en);
		end
	end
endmodule : io_cell
`default_nettype wire

// [verification/io_cell_array_properties.sv]
// assertion checker for the i/o cell array ports
`timescale 1ns/1ps
`default_nettype none
module io_cell_array_checker
	import io_cell_pkg::*;
(
	// clock, reset and apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// chip pins and cell controls
	input wire logic chip_reset_n,
	input wire logic chip_oe_n,
	input wire logic [5:0] ded_in,
	input wire logic [7:0] lc_hold_gate,
	input wire logic [7:0] lc_pin_drive,
	// outputs watched
	input wire logic [11:0] row_chan_out,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic low_skew_net_0
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	cell_cfg_t cfg [8];
	logic [7:0] ctrl;
	logic wr;
	logic tri_all;
	// completed apb writes, and the chip-wide tri-state condition
	assign wr = psel && penable && pwrite && pready;
	assign tri_all = ctrl[0] && !chip_oe_n;
	// shadow of the control word and the cell words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				cfg[i] <= '0;
			end
		end else if (wr && paddr == 12'h000) begin
			ctrl <= pwdata[7:0];
		end else if (wr && paddr >= 12'h010 && paddr <= 12'h02C && paddr[1:0] == 2'h0) begin
			cfg[paddr[4:2] - 3'h4] <= pwdata;
		end
	end
	// per-cell pin and register behaviour
	for (genvar c = 0; c < 8; c++) begin : g_cell
		logic ro;
		logic hold;
		assign ro = cfg[c].dir == DIR_OUT && cfg[c].reg_use == REG_OUT;
		assign hold = ro && chip_reset_n && !lc_hold_gate[c] && cfg[c].ce_sel == 4'h6
			&& cfg[c].clr_sel == 2'h0;
		sequence s_wipe;
			!chip_reset_n ##1 (!chip_reset_n && ro);
		endsequence
		AST_INPUT_NO_DRIVE: assert property (cfg[c].dir == DIR_IN |=> !pad_oe[c])
			else $error("input cell drives its pin");
		AST_DRIVE_ALWAYS: assert property (cfg[c].dir == DIR_OUT && cfg[c].oe_sel == 4'hF && !tri_all
			|=> pad_oe[c]) else $error("output cell not driving");
		AST_LC_DRIVE: assert property (cfg[c].dir == DIR_OUT && cfg[c].oe_sel == 4'h8 && !tri_all
			|=> pad_oe[c] == $past(lc_pin_drive[c])) else $error("logic cell drive not followed");
		AST_GATE_HOLD: assert property (hold [*2] |=> $stable(pad_out[c]))
			else $error("gated register changed");
		AST_CHIP_RESET: assert property (s_wipe |=> !pad_out[c])
			else $error("chip reset did not clear register");
		if (c < 6) begin : g_row
			AST_ROW_PAIR: assert property (row_chan_out[2*c] == row_chan_out[2*c+1])
				else $error("row channel pair differs");
		end
	end
	AST_CHIP_TRISTATE: assert property (tri_all |=> pad_oe == 8'h00)
		else $error("pins driven under chip output disable");
	AST_GLOBAL_PIN: assert property (!ctrl[4] |=> low_skew_net_0 == $past(ded_in[0]))
		else $error("global net 0 not following its pin");
endmodule : io_cell_array_checker

bind io_cell_array io_cell_array_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .chip_reset_n, .chip_oe_n, .ded_in, .lc_hold_gate,
	.lc_pin_drive, .row_chan_out, .pad_out, .pad_oe, .low_skew_net_0);
`default_nettype wire

// [verification/pad_board.sv]
// board model: pins with pull-ups and tied dedicated inputs
`timescale 1ns/1ps
`default_nettype none
module pad_board (
	// pin side of the device
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	// what the board drives
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	input wire logic [5:0] ded_val,
	output logic [5:0] ded_in,
	output logic [7:0] pad_in
);
	// released pins rise to the pull-up level
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'h1);
		end
	end
	// dedicated inputs always held at a known level, never floating
	assign ded_in = ded_val;
endmodule : pad_board
`default_nettype wire

// [verification/tb_io_cell_array.sv]
// self-checking testbench for the i/o cell array
`timescale 1ns/1ps
`default_nettype none
module tb_io_cell_array;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chip_reset_n, chip_oe_n;
	logic [11:0] paddr, logic_row_drive, row_chan_out;
	logic [31:0] pwdata, prdata;
	logic [5:0] ded_in, ded_val;
	logic [1:0] ded_clk;
	logic [7:0] lc_hold_gate, lc_pin_drive, row_chan_in, pad_in, pad_out, pad_oe, ext_en, ext_val;
	logic [23:0] col_chan_in;
	logic [3:0] col_chan_out, gnet;
	int fails, n_compared, cyc;
	// device and board
	io_cell_array dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .chip_reset_n, .chip_oe_n, .ded_in, .ded_clk, .logic_row_drive,
		.lc_hold_gate, .lc_pin_drive, .row_chan_in, .col_chan_in, .row_chan_out,
		.col_chan_out, .pad_in, .pad_out, .pad_oe, .low_skew_net_0(gnet[0]),
		.low_skew_net_1(gnet[1]), .low_skew_net_2(gnet[2]), .low_skew_net_3(gnet[3]));
	pad_board brd (.pad_out, .pad_oe, .ext_en, .ext_val, .ded_val, .ded_in, .pad_in);
	// clock
	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			complete_run();
		end
	end
	task complete_run();
		if (fails == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// wait for pready; if it never comes, only the hang guard ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0, r, e);
		if (!xe) chk(r, x);
		chk(32'(e), 32'(xe));
	endtask : rd
	task wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
		chk(32'(e), 32'(xe));
	endtask : wr
	task pulse();
		ded_clk[0] <= 1'h0;
		tick(2);
		ded_clk[0] <= 1'h1;
		tick(4);
	endtask : pulse
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, ded_val, ded_clk, logic_row_drive} = '0;
		{lc_hold_gate, lc_pin_drive, row_chan_in, col_chan_in, ext_en, ext_val} = '0;
		{chip_reset_n, chip_oe_n, presetn} = 3'h6;
		{fails, n_compared, cyc} = '0;
		tick(12);
		presetn <= 1'h1;
		rd(12'h000, 32'h0, 1'h0);
		rd(12'h004, 32'hFFF, 1'h0);
		rd(12'h01C, 32'h0, 1'h0);
		rd(12'h040, 32'h0, 1'h1);
		wr(12'h030, 32'h1, 1'h1);
		ext_en <= 8'h01;
		ext_val <= 8'h01;
		tick(4);
		chk(32'(row_chan_out[1:0]), 32'h3);
		chk(32'(pad_oe[0]), 32'h0);
		wr(12'h010, 32'h0F24, 1'h0);
		pulse();
		ext_val <= 8'h00;
		tick(4);
		chk(32'(row_chan_out[1:0]), 32'h3);
		pulse();
		chk(32'(row_chan_out[1:0]), 32'h0);
		wr(12'h014, 32'h0003_FF01, 1'h0);
		row_chan_in <= 8'h08;
		tick(4);
		chk(32'({pad_oe[1], pad_out[1]}), 32'h3);
		lc_hold_gate <= 8'h02;
		wr(12'h014, 32'h0003_F629, 1'h0);
		pulse();
		chk(32'(pad_out[1]), 32'h1);
		lc_hold_gate <= 8'h00;
		row_chan_in <= 8'h00;
		pulse();
		chk(32'(pad_out[1]), 32'h1);
		chip_reset_n <= 1'h0;
		lc_hold_gate <= 8'h02;
		row_chan_in <= 8'h08;
		pulse();
		chk(32'(pad_out[1]), 32'h0);
		chip_reset_n <= 1'h1;
		wr(12'h014, 32'h0003_8629, 1'h0);
		tick(4);
		chk(32'(pad_oe[1]), 32'h0);
		lc_pin_drive <= 8'h02;
		chip_oe_n <= 1'h0;
		tick(4);
		chk(32'(pad_oe[1]), 32'h1);
		wr(12'h000, 32'h1, 1'h0);
		tick(4);
		chk(32'(pad_oe), 32'h0);
		ded_val <= 6'h0A;
		tick(4);
		chk(32'(gnet), 32'hA);
		wr(12'h004, 32'hFBF, 1'h0);
		wr(12'h000, 32'h10, 1'h0);
		logic_row_drive <= 12'h040;
		tick(4);
		chk(32'(gnet), 32'hB);
		wr(12'h028, 32'h0020_0000, 1'h0);
		ext_en <= 8'h41;
		ext_val <= 8'h40;
		tick(4);
		chk(32'(col_chan_out[1:0]), 32'h3);
		// registered bidir: output register in the cell, enable from a neighbouring logic cell
		wr(12'h018, 32'h0003_8F2A, 1'h0);
		ext_en <= 8'h45;
		tick(4);
		chk(32'(row_chan_out[5:4]), 32'h0);
		lc_pin_drive <= 8'h06;
		pulse();
		chk(32'({pad_oe[2], row_chan_out[5:4]}), 32'h7);
		complete_run();
	end
endmodule : tb_io_cell_array
`default_nettype wire
